// [hw/anp_lh_bit.sv]
// latched-high status flag, cleared by a read strobe
// assumes set and clear come from logic on the same clock
`timescale 1ns/10ps
module anp_lh_bit (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	// event and read clear
	input wire logic i_set,
	input wire logic i_clr,
	// flag
	output logic o_flag
);

	logic flag_q;
	logic flag_d;

	// set beats clear so an event during the read is not lost
	always_comb begin
		flag_d = i_set | (flag_q & ~i_clr);
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			flag_q <= 1'h0;
		end else begin
			flag_q <= flag_d;
		end
	end

	assign o_flag = flag_q;

endmodule

// [hw/anp_regs.sv]
// partner page, expansion and local next page registers behind the serial management pins
// assumes the negotiation engine drives its strobes on i_ref_clk and that the management
// clock runs well below one eighth of i_ref_clk, since it is oversampled through two flops
`timescale 1ns/10ps
module anp_regs (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	// management pins
	input wire logic i_mdc,
	input wire logic i_mdio,
	output logic o_mdio,
	output logic o_mdio_oe,
	input wire logic [4:0] i_phy_addr,
	// negotiation engine
	input wire logic i_an_restart,
	input wire logic i_rx_word_valid,
	input wire logic [15:0] i_rx_word,
	input wire logic i_pd_multi_link,
	input wire logic i_partner_an_able,
	input wire logic i_tx_page_sent,
	// to the negotiation engine
	output logic [15:0] o_local_next_page,
	output logic o_page_received
);

	// ******************************
	// pin synchronisers
	// ******************************
	logic [anp_pkg::ANP_SYNC_WIDTH-1:0] pins_s;
	logic mdc_s;
	logic mdio_s;
	logic [4:0] phy_addr_s;

	anp_sync #(
		.WIDTH(anp_pkg::ANP_SYNC_WIDTH)
	) u_sync (
		.i_ref_clk(i_ref_clk),
		.i_reset_n(i_reset_n),
		.i_async({i_phy_addr, i_mdio, i_mdc}),
		.o_sync(pins_s)
	);

	assign mdc_s = pins_s[0];
	assign mdio_s = pins_s[1];
	assign phy_addr_s = pins_s[6:2];

	// ******************************
	// frame engine state
	// ******************************
	anp_pkg::anp_state_e state_q;
	anp_pkg::anp_state_e state_d;
	logic mdc_prev_q;
	logic [5:0] cnt_q;
	logic [5:0] cnt_d;
	logic [15:0] shift_q;
	logic [15:0] shift_d;
	logic [15:0] snap_q;
	logic [15:0] snap_d;
	logic [4:0] reg_q;
	logic [4:0] reg_d;
	logic rd_q;
	logic rd_d;
	logic wr_q;
	logic wr_d;
	logic mdio_q;
	logic mdio_d;
	logic oe_q;
	logic oe_d;
	logic mdc_rise;
	logic [12:0] hdr;
	logic hdr_hit;
	logic rd_strobe;
	logic wr_strobe;
	logic [15:0] wr_data;
	logic [15:0] rd_word;

	assign mdc_rise = mdc_s & ~mdc_prev_q;
	assign hdr = {shift_q[11:0], mdio_s};
	assign hdr_hit = hdr[12] && (hdr[9:5] == phy_addr_s)
		&& ((hdr[4:0] == anp_pkg::ANP_REG_PARTNER) || (hdr[4:0] == anp_pkg::ANP_REG_EXPAND)
		|| (hdr[4:0] == anp_pkg::ANP_REG_NEXTPG));
	assign wr_data = {shift_q[14:0], mdio_s};

	// ******************************
	// frame engine next state
	// ******************************
	// frames for other addresses are not answered so other register blocks may drive
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		shift_d = shift_q;
		snap_d = snap_q;
		reg_d = reg_q;
		rd_d = rd_q;
		wr_d = wr_q;
		mdio_d = mdio_q;
		oe_d = oe_q;
		rd_strobe = 1'h0;
		wr_strobe = 1'h0;
		if (mdc_rise) begin
			unique case (state_q)
				anp_pkg::ANP_ST_IDLE: begin
					if (mdio_s) begin
						if (cnt_q != anp_pkg::ANP_PREAMBLE_LEN) begin
							cnt_d = cnt_q + 6'h01;
						end
					end else if (cnt_q == anp_pkg::ANP_PREAMBLE_LEN) begin
						state_d = anp_pkg::ANP_ST_HDR;
						cnt_d = 6'h00;
					end else begin
						cnt_d = 6'h00;
					end
				end
				anp_pkg::ANP_ST_HDR: begin
					shift_d = {shift_q[14:0], mdio_s};
					cnt_d = cnt_q + 6'h01;
					if (cnt_q == anp_pkg::ANP_HDR_LAST) begin
						cnt_d = 6'h00;
						reg_d = hdr[4:0];
						rd_d = hdr_hit && (hdr[11:10] == anp_pkg::ANP_OP_READ);
						wr_d = hdr_hit && (hdr[11:10] == anp_pkg::ANP_OP_WRITE);
						if (rd_d || wr_d) begin
							state_d = anp_pkg::ANP_ST_TURN;
						end else begin
							state_d = anp_pkg::ANP_ST_IDLE;
						end
						if (rd_d) begin
							snap_d = rd_word;
							rd_strobe = 1'h1;
						end
					end
				end
				anp_pkg::ANP_ST_TURN: begin
					cnt_d = cnt_q + 6'h01;
					if (rd_q) begin
						oe_d = 1'h1;
						mdio_d = 1'h0;
					end
					if (cnt_q == anp_pkg::ANP_TURN_LAST) begin
						state_d = anp_pkg::ANP_ST_DATA;
						cnt_d = 6'h00;
						if (rd_q) begin
							mdio_d = snap_q[15];
							snap_d = {snap_q[14:0], 1'h0};
						end
					end
				end
				anp_pkg::ANP_ST_DATA: begin
					shift_d = {shift_q[14:0], mdio_s};
					cnt_d = cnt_q + 6'h01;
					mdio_d = snap_q[15];
					snap_d = {snap_q[14:0], 1'h0};
					if (cnt_q == anp_pkg::ANP_DATA_LAST) begin
						wr_strobe = wr_q;
						state_d = anp_pkg::ANP_ST_IDLE;
						cnt_d = 6'h00;
						oe_d = 1'h0;
						mdio_d = 1'h0;
						rd_d = 1'h0;
						wr_d = 1'h0;
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_q <= anp_pkg::ANP_ST_IDLE;
			mdc_prev_q <= 1'h0;
			cnt_q <= 6'h00;
			shift_q <= 16'h0000;
			snap_q <= 16'h0000;
			reg_q <= 5'h00;
			rd_q <= 1'h0;
			wr_q <= 1'h0;
			mdio_q <= 1'h0;
			oe_q <= 1'h0;
		end else begin
			state_q <= state_d;
			mdc_prev_q <= mdc_s;
			cnt_q <= cnt_d;
			shift_q <= shift_d;
			snap_q <= snap_d;
			reg_q <= reg_d;
			rd_q <= rd_d;
			wr_q <= wr_d;
			mdio_q <= mdio_d;
			oe_q <= oe_d;
		end
	end

	assign o_mdio = mdio_q;
	assign o_mdio_oe = oe_q;

	// ******************************
	// partner ability words
	// ******************************
	logic [15:0] base_q;
	logic [15:0] base_d;
	logic [15:0] next_q;
	logic [15:0] next_d;
	logic np_phase_q;
	logic np_phase_d;
	logic an_able_q;
	logic an_able_d;
	logic show_next_q;
	logic show_next_d;

	always_comb begin
		base_d = base_q;
		next_d = next_q;
		np_phase_d = np_phase_q;
		show_next_d = show_next_q;
		if (i_an_restart) begin
			np_phase_d = 1'h0;
		end
		if (i_rx_word_valid) begin
			if (np_phase_d) begin
				next_d = i_rx_word;
				show_next_d = 1'h1;
			end else begin
				base_d = i_rx_word;
				np_phase_d = 1'h1;
				// base form shown until a next page lands
				show_next_d = 1'h0;
			end
		end
		an_able_d = i_partner_an_able;
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			base_q <= anp_pkg::ANP_BASE_RESET;
			next_q <= anp_pkg::ANP_NEXT_RESET;
			np_phase_q <= 1'h0;
			an_able_q <= 1'h0;
			show_next_q <= 1'h0;
		end else begin
			base_q <= base_d;
			next_q <= next_d;
			np_phase_q <= np_phase_d;
			an_able_q <= an_able_d;
			show_next_q <= show_next_d;
		end
	end

	// ******************************
	// latched expansion flags
	// ******************************
	logic exp_rd_clr;
	logic pd_fault;
	logic page_rx;

	assign exp_rd_clr = rd_strobe && (reg_d == anp_pkg::ANP_REG_EXPAND);

	anp_lh_bit u_pd_fault (
		.i_ref_clk(i_ref_clk),
		.i_reset_n(i_reset_n),
		.i_set(i_pd_multi_link),
		.i_clr(exp_rd_clr),
		.o_flag(pd_fault)
	);

	anp_lh_bit u_page_rx (
		.i_ref_clk(i_ref_clk),
		.i_reset_n(i_reset_n),
		.i_set(i_rx_word_valid),
		.i_clr(exp_rd_clr),
		.o_flag(page_rx)
	);

	assign o_page_received = page_rx;

	// ******************************
	// local next page word
	// ******************************
	logic np_q;
	logic np_d;
	logic mp_q;
	logic mp_d;
	logic comply_acknowledge_q;
	logic comply_acknowledge_d;
	logic tog_q;
	logic tog_d;
	logic [10:0] code_q;
	logic [10:0] code_d;

	always_comb begin
		np_d = np_q;
		mp_d = mp_q;
		comply_acknowledge_d = comply_acknowledge_q;
		tog_d = tog_q;
		code_d = code_q;
		if (wr_strobe && (reg_q == anp_pkg::ANP_REG_NEXTPG)) begin
			np_d = wr_data[anp_pkg::ANP_NP_BIT];
			mp_d = wr_data[anp_pkg::ANP_MP_BIT];
			comply_acknowledge_d = wr_data[anp_pkg::ANP_COMPLY_ACKNOWLEDGE_BIT];
			tog_d = wr_data[anp_pkg::ANP_TOG_BIT];
			code_d = wr_data[10:0];
		end
		if (i_tx_page_sent) begin
			tog_d = ~tog_q;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			np_q <= anp_pkg::ANP_NP_RESET;
			mp_q <= anp_pkg::ANP_MP_RESET;
			comply_acknowledge_q <= anp_pkg::ANP_COMPLY_ACKNOWLEDGE_RESET;
			tog_q <= anp_pkg::ANP_TOG_RESET;
			code_q <= anp_pkg::ANP_CODE_RESET;
		end else begin
			np_q <= np_d;
			mp_q <= mp_d;
			comply_acknowledge_q <= comply_acknowledge_d;
			tog_q <= tog_d;
			code_q <= code_d;
		end
	end

	assign o_local_next_page = {np_q, 1'h0, mp_q, comply_acknowledge_q, tog_q, code_q};

	// ******************************
	// read data
	// ******************************
	always_comb begin
		rd_word = 16'h0000;
		if (hdr[4:0] == anp_pkg::ANP_REG_PARTNER) begin
			if (show_next_q) begin
				rd_word = next_q;
			end else begin
				rd_word = base_q & anp_pkg::ANP_BASE_MASK;
			end
		end else if (hdr[4:0] == anp_pkg::ANP_REG_EXPAND) begin
			rd_word[anp_pkg::ANP_EXP_NP_ABLE] = 1'h1;
			rd_word[anp_pkg::ANP_EXP_PD_FAULT] = pd_fault;
			rd_word[anp_pkg::ANP_EXP_LP_NP] = base_q[anp_pkg::ANP_NP_BIT];
			rd_word[anp_pkg::ANP_EXP_PAGE_RX] = page_rx;
			rd_word[anp_pkg::ANP_EXP_LP_AN] = an_able_q;
		end else if (hdr[4:0] == anp_pkg::ANP_REG_NEXTPG) begin
			rd_word = o_local_next_page;
		end
	end

endmodule

// [hw/anp_sync.sv]
// two-flop synchroniser, one pair per bit
// assumes each bit is an independent level from outside the clock domain
`timescale 1ns/10ps
module anp_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	// asynchronous levels in, synchronised levels out
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			logic meta_q;
			logic sync_q;
			// first flop feeds only the second
			always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
				if (!i_reset_n) begin
					meta_q <= 1'h0;
					sync_q <= 1'h0;
				end else begin
					meta_q <= i_async[gi];
					sync_q <= meta_q;
				end
			end
			assign o_sync[gi] = sync_q;
		end
	endgenerate

endmodule

// [pkg/anp_pkg.sv]
// constants for the partner page register set and its management frame engine
// assumes one 100 MHz device clock; the management clock arrives as a pin
package anp_pkg;

	// ******************************
	// register offsets
	// ******************************
	localparam logic [4:0] ANP_REG_PARTNER = 5'h05;
	localparam logic [4:0] ANP_REG_EXPAND = 5'h06;
	localparam logic [4:0] ANP_REG_NEXTPG = 5'h07;

	// ******************************
	// field positions
	// ******************************
	localparam int ANP_NP_BIT = 15;
	localparam int ANP_ACK_BIT = 14;
	localparam int ANP_MP_BIT = 13;
	localparam int ANP_COMPLY_ACKNOWLEDGE_BIT = 12;
	localparam int ANP_TOG_BIT = 11;
	localparam int ANP_EXP_PD_FAULT = 4;
	localparam int ANP_EXP_LP_NP = 3;
	localparam int ANP_EXP_NP_ABLE = 2;
	localparam int ANP_EXP_PAGE_RX = 1;
	localparam int ANP_EXP_LP_AN = 0;

	// ******************************
	// reset values and masks
	// ******************************
	localparam logic [15:0] ANP_BASE_RESET = 16'h0001;
	localparam logic [15:0] ANP_NEXT_RESET = 16'h0000;
	localparam logic [15:0] ANP_BASE_MASK = 16'he7ff;
	localparam logic ANP_NP_RESET = 1'h0;
	localparam logic ANP_MP_RESET = 1'h1;
	localparam logic ANP_COMPLY_ACKNOWLEDGE_RESET = 1'h0;
	localparam logic ANP_TOG_RESET = 1'h0;
	localparam logic [10:0] ANP_CODE_RESET = 11'h001;

	// ******************************
	// management frame
	// ******************************
	localparam logic [5:0] ANP_PREAMBLE_LEN = 6'h20;
	localparam logic [5:0] ANP_HDR_LAST = 6'h0c;
	localparam logic [5:0] ANP_TURN_LAST = 6'h01;
	localparam logic [5:0] ANP_DATA_LAST = 6'h0f;
	localparam logic [1:0] ANP_OP_READ = 2'h2;
	localparam logic [1:0] ANP_OP_WRITE = 2'h1;
	localparam int ANP_SYNC_WIDTH = 7;

	typedef enum logic [3:0] {
		ANP_ST_IDLE = 4'h1,
		ANP_ST_HDR = 4'h2,
		ANP_ST_TURN = 4'h4,
		ANP_ST_DATA = 4'h8
	} anp_state_e;

endpackage

// [sim/anp_regs_sva.sv]
// assertions on the pins and engine outputs of the partner page register set
// assumes one device clock and the active-low reset of the bound block
`timescale 1ns/10ps
module anp_regs_sva (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	// watched ports
	input wire logic i_rx_word_valid,
	input wire logic i_tx_page_sent,
	input wire logic o_mdio,
	input wire logic o_mdio_oe,
	input wire logic [15:0] o_local_next_page,
	input wire logic o_page_received
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);
	// **********
	// checks
	// **********
	// the clearing read must go on to its turnaround, never a silent clear
	sequence s_turn;
		##[1:30] $rose(o_mdio_oe);
	endsequence
	a_reset_vals: assert property ($rose(i_reset_n) |->
		o_local_next_page == 16'h2001 && !o_page_received) else $error("bad reset word");
	a_np_reserved: assert property (o_local_next_page[14] == 1'b0)
		else $error("reserved bit set");
	a_rx_set: assert property (i_rx_word_valid |=> o_page_received)
		else $error("page flag not set");
	a_rx_clear: assert property ($fell(o_page_received) |-> s_turn)
		else $error("page flag cleared without read");
	a_tog_flip: assert property (i_tx_page_sent |=>
		o_local_next_page[11] != $past(o_local_next_page[11])) else $error("toggle kept");
	a_ta_zero: assert property ($rose(o_mdio_oe) |-> !o_mdio)
		else $error("turnaround not zero");
	a_idle_low: assert property (!o_mdio_oe |-> !o_mdio)
		else $error("data high while released");
	a_oe_span: assert property ($rose(o_mdio_oe) |-> o_mdio_oe [*8])
		else $error("drive too short");
endmodule
bind anp_regs anp_regs_sva anp_regs_sva_i (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
	.i_rx_word_valid(i_rx_word_valid), .i_tx_page_sent(i_tx_page_sent), .o_mdio(o_mdio),
	.o_mdio_oe(o_mdio_oe), .o_local_next_page(o_local_next_page),
	.o_page_received(o_page_received));

// [sim/anp_station.sv]
// management station model that runs whole frames on the clock and data pins
// assumes a pull-up on the data pin; the clock pin stands low between frames
`timescale 1ns/10ps
module anp_station (
	// clock
	input wire logic i_ref_clk,
	// request
	input wire logic i_go,
	input wire logic i_wr,
	input wire logic [4:0] i_phy,
	input wire logic [4:0] i_reg,
	input wire logic [15:0] i_wdata,
	// pins
	input wire logic i_mdio,
	output logic o_mdc,
	output logic o_mdio,
	output logic o_mdio_oe,
	// answer
	output logic o_done,
	output logic [15:0] o_rdata
);
	logic [63:0] f;
	initial begin
		o_mdc = 1'b0;
		o_mdio = 1'b0;
		o_mdio_oe = 1'b0;
		o_done = 1'b0;
		o_rdata = 16'h0000;
		forever begin
			@(posedge i_ref_clk);
			if (i_go) begin
				f = {32'hffffffff, 2'b01, (i_wr ? 2'b01 : 2'b10), i_phy, i_reg, 2'b10, i_wdata};
				for (int k = 0; k < 64; k++) begin
					#1 o_mdc = 1'b0;
					o_mdio = f[63-k];
					// reads release the pin from the first turnaround bit on
					o_mdio_oe = i_wr | (k < 46);
					repeat (5) @(posedge i_ref_clk);
					if (k >= 48) o_rdata[63-k] = i_mdio;
					#1 o_mdc = 1'b1;
					repeat (4) @(posedge i_ref_clk);
				end
				#1 o_mdc = 1'b0;
				o_mdio_oe = 1'b0;
				o_done = 1'b1;
				@(posedge i_ref_clk);
				#1 o_done = 1'b0;
			end
		end
	end
endmodule

// [sim/testbench.sv]
// self-checking bench for the partner page register set
// assumes the station model drives the management pins
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
	$display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module testbench;
	logic i_ref_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic i_an_restart = 1'b0;
	logic i_rx_word_valid = 1'b0;
	logic [15:0] i_rx_word = 16'h0000;
	logic i_pd_multi_link = 1'b0;
	logic i_partner_an_able = 1'b0;
	logic i_tx_page_sent = 1'b0;
	logic go = 1'b0;
	logic wr = 1'b0;
	logic [4:0] phy = 5'h0b;
	logic [4:0] rg = 5'h05;
	logic [15:0] wd = 16'h0000;
	logic mdc, m_out, m_oe, d_out, d_oe, done, pin, page_rx;
	logic [15:0] rdata, lnp, v, w, e;
	logic [15:0] exp_q[$];
	logic [31:0] seed = 32'h00005e6d;
	int checks = 0;
	int fail_count = 0;
	int cyc = 0;
	// **********
	// pins and instances
	// **********
	assign pin = (d_oe ? d_out : 1'b1) & (m_oe ? m_out : 1'b1);
	always #5 i_ref_clk = ~i_ref_clk;
	anp_regs anp_regs_i (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_mdc(mdc),
		.i_mdio(pin), .o_mdio(d_out), .o_mdio_oe(d_oe), .i_phy_addr(5'h0b),
		.i_an_restart(i_an_restart), .i_rx_word_valid(i_rx_word_valid), .i_rx_word(i_rx_word),
		.i_pd_multi_link(i_pd_multi_link), .i_partner_an_able(i_partner_an_able),
		.i_tx_page_sent(i_tx_page_sent), .o_local_next_page(lnp), .o_page_received(page_rx));
	anp_station anp_station_i (.i_ref_clk(i_ref_clk), .i_go(go), .i_wr(wr), .i_phy(phy),
		.i_reg(rg), .i_wdata(wd), .i_mdio(pin), .o_mdc(mdc), .o_mdio(m_out), .o_mdio_oe(m_oe),
		.o_done(done), .o_rdata(rdata));
	// **********
	// tasks
	// **********
	function logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction
	task automatic tick(int n);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask
	task automatic pulse(ref logic s);
		tick(1);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask
	task automatic frame(logic w_en, logic [4:0] a, logic [4:0] r, logic [15:0] d);
		tick(1);
		wr = w_en;
		phy = a;
		rg = r;
		wd = d;
		go = 1'b1;
		do @(posedge i_ref_clk); while (done !== 1'b1);
		#1 go = 1'b0;
	endtask
	task automatic rd(logic [4:0] a, logic [4:0] r, logic [15:0] x);
		exp_q.push_back(x);
		frame(1'b0, a, r, 16'h0000);
	endtask
	task test_done;
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// **********
	// watcher and timeout
	// **********
	always @(posedge i_ref_clk) begin
		// write frames end with done as well but carry no read data
		if (done === 1'b1 && wr === 1'b0) begin
			e = exp_q.pop_front();
			`CHK(rdata, e)
		end
		cyc++;
		if (cyc == 40000) begin
			fail_count++;
			test_done();
		end
	end
	// **********
	// scenarios
	// **********
	initial begin
		tick(6);
		i_reset_n = 1'b1;
		tick(4);
		rd(5'h0b, 5'h05, 16'h0001);
		rd(5'h0b, 5'h06, 16'h0004);
		rd(5'h0b, 5'h07, 16'h2001);
		rd(5'h0c, 5'h05, 16'hffff);
		rd(5'h0b, 5'h04, 16'hffff);
		v = rnd();
		frame(1'b1, 5'h0b, 5'h07, v);
		`CHK(lnp, v & 16'hbfff)
		rd(5'h0b, 5'h07, v & 16'hbfff);
		pulse(i_tx_page_sent);
		rd(5'h0b, 5'h07, (v & 16'hbfff) ^ 16'h0800);
		i_partner_an_able = 1'b1;
		w = rnd() | 16'h8000;
		i_rx_word = w;
		pulse(i_rx_word_valid);
		`CHK(page_rx, 1'b1)
		rd(5'h0b, 5'h06, 16'h000f);
		rd(5'h0b, 5'h06, 16'h000d);
		rd(5'h0b, 5'h05, w & 16'he7ff);
		w = rnd();
		i_rx_word = w;
		pulse(i_rx_word_valid);
		rd(5'h0b, 5'h05, w);
		rd(5'h0b, 5'h06, 16'h000f);
		pulse(i_pd_multi_link);
		rd(5'h0b, 5'h06, 16'h001d);
		rd(5'h0b, 5'h06, 16'h000d);
		pulse(i_an_restart);
		w = rnd() & 16'h7fff;
		i_rx_word = w;
		pulse(i_rx_word_valid);
		rd(5'h0b, 5'h05, w & 16'he7ff);
		rd(5'h0b, 5'h06, 16'h0007);
		tick(4);
		test_done();
	end
endmodule
